// ==== hdl/tzc_consts.svh ====
// register offsets, field positions, reset values and counts of the timer
`ifndef TZC_CONSTS_SVH
`define TZC_CONSTS_SVH

// register indices; byte address is four times the index
`define TZC_IDX_LOW      14'h059C
`define TZC_IDX_HIGH     14'h059D
`define TZC_IDX_CTRL0    14'h059E
`define TZC_IDX_CTRL1    14'h059F
`define TZC_IDX_IRQ      14'h05A0

// first control register fields
`define TZC_C0_EN        7
`define TZC_C0_OUT       5
`define TZC_C0_WIDE      4
`define TZC_C0_OPS_LSB   0
// second control register fields
`define TZC_C1_CS_LSB    5
`define TZC_C1_ASYNC     4
`define TZC_C1_CKPS_LSB  0
// interrupt register fields
`define TZC_IRQ_FLAG     0
`define TZC_IRQ_IE       1

// reset values
`define TZC_RST_BYTE     8'h00
`define TZC_RST_WORD     32'h0000_0000
`define TZC_RST_PS       15'h0000
`define TZC_RST_POST     4'h0

// counter limits
`define TZC_LOW_MAX      8'hFF
`define TZC_HIGH_MAX     8'hFF
`define TZC_PS_ONES      16'h0001

`endif

// ==== hdl/tzc_pkg.sv ====
// types of the timer block
package tzc_pkg;

  // clock source select codes
  typedef enum logic [2:0] {
    TZC_SRC_PIN      = 3'b000,
    TZC_SRC_PIN_INV  = 3'b001,
    TZC_SRC_INSTR    = 3'b010,
    TZC_SRC_HFOSC    = 3'b011,
    TZC_SRC_LFOSC    = 3'b100,
    TZC_SRC_MFOSC    = 3'b101,
    TZC_SRC_SECOSC   = 3'b110,
    TZC_SRC_LOGIC1   = 3'b111
  } tzc_src_t;

  // whole state of the timer
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [7:0]  low;
    logic [7:0]  cnt_high;
    logic [7:0]  high_reg;
    logic [7:0]  period_buf;
    logic        en;
    logic        wide;
    logic [3:0]  ops;
    tzc_src_t    cs;
    logic        async;
    logic [3:0]  ckps;
    logic [14:0] ps;
    logic [3:0]  post;
    logic        tout;
    logic        flag;
    logic        ie;
    logic        irq;
    logic        sync1;
    logic        sync2;
    logic        sync3;
    logic        async_prev;
  } tzc_state_t;

endpackage

// ==== hdl/tzc_timer.sv ====
// timer with prescaler, period match, 16-bit rollover and postscaler
// Behaviour
// - width select bit picks 8-bit period timer or 16-bit counter
// - 8-bit mode advances once per prescaled rising edge of selected clock
// - 8-bit: low matches period buffer, low clears, buffer reloads from high
// - 16-bit: reading low copies counter high byte into high register
// - 16-bit: high write is buffered, loaded into counter on low write
// - 16-bit: counter wraps FFFF to 0000 and runs freely
// - 16-bit: count bytes never act as a reload value while running
// - source field selects logic cell, oscillators, instruction clock or pin
// - synchronous mode: counting synchronised, at most clock rate, halts in sleep
// - unsynchronized mode: counts each rising source edge, continues during sleep
// - sixteen prescale ratios from 1:1 to 1:32768
// - prescale select n divides by two to the power n
// - prescaler hidden; cleared by low write, control writes, reset
// - postscaler divides match or rollover events by 1 to 16
// - postscaler hidden; cleared by low write, control writes, reset
// - timer output toggles on each postscaled match or rollover
// - timer output goes to a pin and reads back as status bit
// - flag set on each output toggle; interrupt when enable also set
// - flag set once per postscale value plus one events
// - unsynchronized mode keeps counting in sleep and wakes via interrupt
// - enable bit starts and stops counter, zero after reset
`include "tzc_consts.svh"

module tzc_timer (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [15:0]     wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  input  wire logic            ext_clk_pin_i,
  input  wire logic            logic_cell_one_output_i,
  input  wire logic            secondary_oscillator_i,
  input  wire logic            medium_internal_oscillator_i,
  input  wire logic            low_internal_oscillator_i,
  input  wire logic            high_internal_oscillator_i,
  input  wire logic            sleep_i,
  output logic                 timer_output_o,
  output logic                 irq_o
);
  import tzc_pkg::*;

  tzc_state_t st_ff;
  tzc_state_t nxt_st;

  logic        acc;
  logic        wr;
  logic        rd;
  logic [13:0] idx;
  logic        hit_low;
  logic        hit_high;
  logic        hit_c0;
  logic        hit_c1;
  logic        hit_irq;
  logic        src_raw;
  logic        src_edge;
  logic [14:0] ps_mask;
  logic        ps_tick;
  logic        run;
  logic        evt;
  logic        post_hit;
  logic        clr_scalers;
  logic [15:0] wide_inc;

  // bus decode; one access per request, ack drops the cycle after
  always_comb
  begin
    acc      = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    wr       = acc & wb_we_i & wb_sel_i[0];
    rd       = acc & ~wb_we_i;
    idx      = wb_adr_i[15:2];
    hit_low  = (idx == `TZC_IDX_LOW);
    hit_high = (idx == `TZC_IDX_HIGH);
    hit_c0   = (idx == `TZC_IDX_CTRL0);
    hit_c1   = (idx == `TZC_IDX_CTRL1);
    hit_irq  = (idx == `TZC_IDX_IRQ);
  end

  // clock source mux; pin code 001 is the inverted pin
  always_comb
  begin
    case (st_ff.cs)
      TZC_SRC_PIN:     src_raw = ext_clk_pin_i;
      TZC_SRC_PIN_INV: src_raw = ~ext_clk_pin_i;
      TZC_SRC_INSTR:   src_raw = 1'b1;
      TZC_SRC_HFOSC:   src_raw = high_internal_oscillator_i;
      TZC_SRC_LFOSC:   src_raw = low_internal_oscillator_i;
      TZC_SRC_MFOSC:   src_raw = medium_internal_oscillator_i;
      TZC_SRC_SECOSC:  src_raw = secondary_oscillator_i;
      TZC_SRC_LOGIC1:  src_raw = logic_cell_one_output_i;
      default:         src_raw = 1'b0;
    endcase
  end

  // edge picking: instruction clock counts every cycle; synchronous mode
  // looks only at the second and third stage, so the first stage stays clean
  always_comb
  begin
    if (st_ff.cs == TZC_SRC_INSTR)
      src_edge = 1'b1;
    else if (st_ff.async)
      src_edge = src_raw & ~st_ff.async_prev;
    else
      src_edge = st_ff.sync2 & ~st_ff.sync3;
  end

  // sync mode halts in sleep since the system clock is gone there;
  // unsynchronized mode keeps going as long as its source toggles
  always_comb
  begin
    run = st_ff.en & (st_ff.async | ~sleep_i);
  end

  // prescaler: ratio 2**n, tick when the low n bits are all ones
  always_comb
  begin
    ps_mask = 15'((`TZC_PS_ONES << st_ff.ckps) - `TZC_PS_ONES);
    ps_tick = run & src_edge & ((st_ff.ps & ps_mask) == ps_mask);
    clr_scalers = wr & (hit_low | hit_c0 | hit_c1);
  end

  // counter events: period match or 16-bit wrap
  always_comb
  begin
    wide_inc = {st_ff.cnt_high, st_ff.low} + 16'h0001;
    if (st_ff.wide)
      evt = ps_tick & (st_ff.cnt_high == `TZC_HIGH_MAX)
            & (st_ff.low == `TZC_LOW_MAX);
    else
      evt = ps_tick & (st_ff.low == st_ff.period_buf);
    post_hit = evt & (st_ff.post == st_ff.ops);
  end

  // next state of the whole block
  always_comb
  begin
    nxt_st       = st_ff;
    nxt_st.ack   = acc;
    nxt_st.sync1 = src_raw;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    nxt_st.async_prev = src_raw;

    // prescaler counter
    if (run & src_edge)
      nxt_st.ps = ((st_ff.ps & ps_mask) == ps_mask) ? `TZC_RST_PS
                                                     : st_ff.ps + 15'h0001;
    // main counter
    if (ps_tick)
    begin
      if (st_ff.wide)
      begin
        nxt_st.low      = wide_inc[7:0];
        nxt_st.cnt_high = wide_inc[15:8];
      end
      else if (evt)
      begin
        nxt_st.low        = `TZC_RST_BYTE;
        nxt_st.period_buf = st_ff.high_reg;
      end
      else
      begin
        nxt_st.low = st_ff.low + 8'h01;
      end
    end

    // postscaler and output toggle; the flag is set after the write path
    if (evt)
      nxt_st.post = post_hit ? `TZC_RST_POST : st_ff.post + 4'h1;
    if (post_hit)
    begin
      nxt_st.tout = ~st_ff.tout;
    end

    // read path; unmapped reads answer zero
    nxt_st.dat = `TZC_RST_WORD;
    if (rd)
    begin
      if (hit_low)
      begin
        nxt_st.dat[7:0] = st_ff.low;
        if (st_ff.wide)
          nxt_st.high_reg = st_ff.cnt_high;
      end
      if (hit_high)
        nxt_st.dat[7:0] = st_ff.high_reg;
      if (hit_c0)
      begin
        nxt_st.dat[`TZC_C0_EN]   = st_ff.en;
        nxt_st.dat[`TZC_C0_OUT]  = st_ff.tout;
        nxt_st.dat[`TZC_C0_WIDE] = st_ff.wide;
        nxt_st.dat[`TZC_C0_OPS_LSB +: 4] = st_ff.ops;
      end
      if (hit_c1)
      begin
        nxt_st.dat[`TZC_C1_CS_LSB +: 3]   = st_ff.cs;
        nxt_st.dat[`TZC_C1_ASYNC]         = st_ff.async;
        nxt_st.dat[`TZC_C1_CKPS_LSB +: 4] = st_ff.ckps;
      end
      if (hit_irq)
      begin
        nxt_st.dat[`TZC_IRQ_FLAG] = st_ff.flag;
        nxt_st.dat[`TZC_IRQ_IE]   = st_ff.ie;
      end
    end

    // write path; only byte lane 0 carries register data
    if (wr)
    begin
      if (hit_low)
      begin
        nxt_st.low = wb_dat_i[7:0];
        if (st_ff.wide)
          nxt_st.cnt_high = st_ff.high_reg;
      end
      if (hit_high)
        nxt_st.high_reg = wb_dat_i[7:0];
      if (hit_c0)
      begin
        nxt_st.en   = wb_dat_i[`TZC_C0_EN];
        nxt_st.wide = wb_dat_i[`TZC_C0_WIDE];
        nxt_st.ops  = wb_dat_i[`TZC_C0_OPS_LSB +: 4];
      end
      if (hit_c1)
      begin
        nxt_st.cs    = tzc_src_t'(wb_dat_i[`TZC_C1_CS_LSB +: 3]);
        nxt_st.async = wb_dat_i[`TZC_C1_ASYNC];
        nxt_st.ckps  = wb_dat_i[`TZC_C1_CKPS_LSB +: 4];
      end
      if (hit_irq)
      begin
        nxt_st.ie = wb_dat_i[`TZC_IRQ_IE];
        // software clears the flag by writing one to it
        if (wb_dat_i[`TZC_IRQ_FLAG])
          nxt_st.flag = 1'b0;
      end
    end

    // scaler clears override any count in the same cycle
    if (clr_scalers)
    begin
      nxt_st.ps   = `TZC_RST_PS;
      nxt_st.post = `TZC_RST_POST;
    end

    // a toggle in the clearing cycle still sets the flag
    if (post_hit)
      nxt_st.flag = 1'b1;
    nxt_st.irq = nxt_st.flag & nxt_st.ie;
  end

  // single state register, synchronous reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flip-flops
  assign wb_dat_o       = st_ff.dat;
  assign wb_ack_o       = st_ff.ack;
  assign timer_output_o = st_ff.tout;
  assign irq_o          = st_ff.irq;

  // checking
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_disabled_hold: assert property (
    (!st_ff.en && !(wb_cyc_i && wb_stb_i)) |=> $stable(st_ff.low) && $stable(st_ff.ps)
      && $stable(st_ff.post))
    else $error("disabled timer changed its counters");

  a_flag_on_toggle: assert property (
    (st_ff.tout != $past(st_ff.tout)) |-> st_ff.flag)
    else $error("output toggled without setting flag");

  a_toggle_cause: assert property (
    post_hit |=> (st_ff.tout != $past(st_ff.tout)))
    else $error("postscaled event did not toggle output");

  a_period_clear: assert property (
    (ps_tick && !st_ff.wide && st_ff.low == st_ff.period_buf && !wr)
      |=> st_ff.low == 8'h00 && st_ff.period_buf == $past(st_ff.high_reg))
    else $error("period match did not clear low byte");

  a_eight_step: assert property (
    (ps_tick && !st_ff.wide && st_ff.low != st_ff.period_buf && !wr)
      |=> st_ff.low == $past(st_ff.low) + 8'h01)
    else $error("8-bit counter did not advance by one");

  a_wide_wrap: assert property (
    (ps_tick && st_ff.wide && st_ff.low == 8'hFF && st_ff.cnt_high == 8'hFF && !wr)
      |=> st_ff.low == 8'h00 && st_ff.cnt_high == 8'h00)
    else $error("16-bit counter did not wrap to zero");

  a_high_latch: assert property (
    (rd && hit_low && st_ff.wide) |=> st_ff.high_reg == $past(st_ff.cnt_high))
    else $error("low read did not latch high byte");

  a_high_load: assert property (
    (wr && hit_low && st_ff.wide) |=> st_ff.cnt_high == $past(st_ff.high_reg))
    else $error("low write did not load buffered high byte");

  a_scaler_clear: assert property (
    (wr && (hit_low || hit_c0 || hit_c1)) |=> st_ff.ps == 15'h0000 && st_ff.post == 4'h0)
    else $error("scalers not cleared by write");

  a_sleep_halt: assert property (
    (sleep_i && !st_ff.async && !acc) |=> $stable(st_ff.low) && $stable(st_ff.ps))
    else $error("synchronous timer ran during sleep");

  a_ack_pulse: assert property (
    acc |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle");

  // scalers count one step per qualifying edge unless a write clears them
  a_ps_step: assert property (
    (run && src_edge && !clr_scalers && ((st_ff.ps & ps_mask) != ps_mask))
      |=> st_ff.ps == $past(st_ff.ps) + 15'h0001)
    else $error("prescaler did not step by one");

  a_post_step: assert property (
    (evt && st_ff.post != st_ff.ops && !clr_scalers)
      |=> st_ff.post == $past(st_ff.post) + 4'h1)
    else $error("postscaler did not count the event");

  a_post_wrap: assert property (
    (post_hit && !clr_scalers) |=> st_ff.post == 4'h0)
    else $error("postscaler did not restart after its last event");

  // a carry out of the low byte must reach the high byte in the same tick
  a_wide_step: assert property (
    (ps_tick && st_ff.wide && !wr)
      |=> st_ff.low == $past(st_ff.low) + 8'h01
        && st_ff.cnt_high == $past(st_ff.cnt_high)
           + (($past(st_ff.low) == 8'hFF) ? 8'h01 : 8'h00))
    else $error("16-bit counter did not advance by one");

  // the flag only falls on a write of one, and a clear loses to a new toggle
  a_flag_sticky: assert property (
    (st_ff.flag && !(wr && hit_irq && wb_dat_i[`TZC_IRQ_FLAG])) |=> st_ff.flag)
    else $error("flag dropped without a clear");

  a_flag_clear: assert property (
    (wr && hit_irq && wb_dat_i[`TZC_IRQ_FLAG] && !post_hit) |=> !st_ff.flag)
    else $error("flag not cleared by a write of one");

  a_idle_flag: assert property (
    (!st_ff.en && !st_ff.flag && !(wb_cyc_i && wb_stb_i)) |=> !st_ff.flag)
    else $error("disabled timer set its flag");

  a_status_read: assert property (
    (rd && hit_c0) |=> wb_dat_o[`TZC_C0_OUT] == $past(st_ff.tout))
    else $error("status bit does not match timer output");

  c_period_match: cover property (evt && !st_ff.wide);
  c_wide_wrap:    cover property (evt && st_ff.wide);
  c_post_toggle:  cover property (post_hit && st_ff.ops != 4'h0);
  c_irq_raise:    cover property (!irq_o ##1 irq_o);
  c_sleep_count:  cover property (sleep_i && st_ff.async && ps_tick);

endmodule // tzc_timer

// ==== test/tzc_src_model.sv ====
// clock sources outside the timer: oscillators, logic cell output and pin
module tzc_src_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      pin_o,
  output logic      logic1_o,
  output logic      sec_o,
  output logic      med_o,
  output logic      low_o,
  output logic      high_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] div_ff;

  // free running divider, changes just after the edge like a real source
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_ff <= 5'h00;
    else
      div_ff <= div_ff + 5'h01;
  end

  // a distinct rate per source except pin and medium, both div_ff[2]; other wrong selects show as a wrong period
  assign logic1_o = div_ff[0];
  assign high_o   = div_ff[1];
  assign med_o    = div_ff[2];
  assign pin_o    = div_ff[2];
  assign low_o    = div_ff[3];
  assign sec_o    = div_ff[4];
endmodule // tzc_src_model

// ==== test/tb_timer_zero_counter.sv ====
// self-checking bench of the timer over its register bus
`include "tzc_consts.svh"
module tb_timer_zero_counter;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic        sleep = 1'b0;
  logic [15:0] adr   = 16'h0000;
  logic [31:0] dw    = 32'h0000_0000;
  logic [31:0] dr;
  logic [31:0] q;
  logic [31:0] q2;
  logic        ack, tout, irq, pin, lg1, sec, med, lfo, hfo;
  int          errors = 0;
  int          checks_done = 0;
  int          cyc_cnt = 0;
  int          n, i;
  int          per [8] = '{8, 8, 1, 4, 16, 8, 32, 2};

  always #4 clk_i = ~clk_i;

  tzc_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .ext_clk_pin_i(pin), .logic_cell_one_output_i(lg1), .secondary_oscillator_i(sec),
    .medium_internal_oscillator_i(med), .low_internal_oscillator_i(lfo),
    .high_internal_oscillator_i(hfo), .sleep_i(sleep), .timer_output_o(tout), .irq_o(irq));

  tzc_src_model SRC (.clk_i(clk_i), .rst_i(rst_i), .pin_o(pin), .logic1_o(lg1), .sec_o(sec),
    .med_o(med), .low_o(lfo), .high_o(hfo));

  task automatic close_out();
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [13:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    dw  <= {24'h000000, d};
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd_chk(input logic [13:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk(q, {24'h000000, e});
  endtask

  // cycles until the output changes, giving up after lim;
  // the leading negedge counts as the first cycle, so a gap of g cycles reads as g
  task automatic wait_tog(input int lim);
    logic t;
    n = 1;
    @(negedge clk_i);
    t = tout;
    while (tout === t && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
  endtask

  // first toggle may be uneven after a reconfiguration, so measure the next
  task automatic gap_chk(input int e);
    wait_tog(3000);
    wait_tog(3000);
    chk(n, e);
  endtask

  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 5; i++)
      rd_chk(14'(`TZC_IDX_LOW + i), 8'h00);
    rd_chk(14'h0100, 8'h00);
    wb(1'b1, `TZC_IDX_CTRL1, 8'h40);
    wb(1'b1, `TZC_IDX_CTRL0, 8'h10);
    wb(1'b1, `TZC_IDX_HIGH, 8'h12);
    wb(1'b1, `TZC_IDX_LOW, 8'h34);
    wb(1'b1, `TZC_IDX_HIGH, 8'h56);
    rd_chk(`TZC_IDX_LOW, 8'h34);
    rd_chk(`TZC_IDX_HIGH, 8'h12);
    wb(1'b1, `TZC_IDX_HIGH, 8'hFF);
    wb(1'b1, `TZC_IDX_LOW, 8'hF0);
    wb(1'b1, `TZC_IDX_CTRL0, 8'h90);
    wait_tog(40);
    chk(32'(n < 40), 32'h1);
    wb(1'b0, `TZC_IDX_LOW, 8'h00);
    rd_chk(`TZC_IDX_HIGH, 8'h00);
    // 8-bit mode with a period of one
    wb(1'b1, `TZC_IDX_CTRL0, 8'h00);
    wb(1'b1, `TZC_IDX_LOW, 8'h00);
    wb(1'b1, `TZC_IDX_HIGH, 8'h01);
    wb(1'b1, `TZC_IDX_CTRL0, 8'h80);
    gap_chk(2);
    wb(1'b1, `TZC_IDX_CTRL0, 8'h00);
    wb(1'b0, `TZC_IDX_CTRL0, 8'h00);
    chk(q[5], tout);
    rd_chk(`TZC_IDX_IRQ, 8'h01);
    chk(irq, 1'b0);
    wb(1'b1, `TZC_IDX_IRQ, 8'h02);
    @(negedge clk_i);
    chk(irq, 1'b1);
    wb(1'b1, `TZC_IDX_IRQ, 8'h03);
    rd_chk(`TZC_IDX_IRQ, 8'h02);
    chk(irq, 1'b0);
    // every source code; pin, inverted pin and medium share one rate
    for (i = 0; i < 8; i++)
    begin
      wb(1'b1, `TZC_IDX_CTRL1, {i[2:0], 5'h00});
      wb(1'b1, `TZC_IDX_CTRL0, 8'h80);
      gap_chk(2 * per[i]);
    end
    for (i = 0; i < 4; i++)
    begin
      wb(1'b1, `TZC_IDX_CTRL1, {4'h4, i[3:0]});
      gap_chk(2 << i);
    end
    wb(1'b1, `TZC_IDX_CTRL1, 8'h40);
    for (i = 0; i < 4; i++)
    begin
      wb(1'b1, `TZC_IDX_CTRL0, {4'h8, i[3:0]});
      gap_chk(2 * (i + 1));
    end
    // sleep halts synchronous counting, not unsynchronized
    wb(1'b1, `TZC_IDX_CTRL1, 8'h00);
    sleep <= 1'b1;
    wait_tog(200);
    chk(n, 200);
    wb(1'b1, `TZC_IDX_CTRL1, 8'h10);
    // pin edge every 8 cycles, two counts per period, postscale 1:4 still set
    gap_chk(64);
    sleep <= 1'b0;
    wb(1'b1, `TZC_IDX_CTRL0, 8'h00);
    wb(1'b0, `TZC_IDX_LOW, 8'h00);
    q2 = q;
    repeat (20) @(posedge clk_i);
    rd_chk(`TZC_IDX_LOW, q2[7:0]);
    close_out();
  end

  // cuts a hang short
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 40000)
    begin
      errors++;
      close_out();
    end
  end
endmodule // tb_timer_zero_counter
